// file: sim/aprl_host.sv
`timescale 1ns/1ps
// host on the config bus: one access per cycle, back to back until idle
module aprl_host (
    input wire logic clk_i,
    output aprl_pkg::aprl_cfg_req_t cfg_req_o
);
    import aprl_pkg::*;
    logic [31:0] exp_q[$];
    initial cfg_req_o = '0;
    // request held to the next edge; writes answer with zero data
    task automatic access(input logic wr, input logic [9:0] a, input logic [31:0] d,
                          input logic [31:0] e);
        @(posedge clk_i);
        #1;
        cfg_req_o = '{1'b1, wr, a, d};
        exp_q.push_back(e);
    endtask
    task automatic idle();
        @(posedge clk_i);
        #1;
        cfg_req_o = '0;
    endtask
endmodule // aprl_host

// file: sim/aprl_regmap_bench.sv
`timescale 1ns/1ps
module aprl_regmap_bench;
    import aprl_pkg::*;
    localparam logic [9:0] RW_OFS[16] = '{OFS_PWR, OFS_PIN_FUNCTION_SELECT, OFS_PIN_DIRECTION, OFS_POUT, OFS_MUTE,
        OFS_SPDIF, OFS_RX_MASK, OFS_RX_FMT, OFS_RX_FS, OFS_RX_BCLK, OFS_RX_HCLK,
        OFS_RX_SLOTS, OFS_RX_INTEN, OFS_RX_EVT, OFS_TX_MASK, OFS_TX_FMT};
    localparam int LB_EN[6] = '{0, 1, 1, 1, 1, 1};
    localparam int LB_SLOT[6] = '{2, 1, 2, 32, 33, 0};
    localparam int LB_EXP[6] = '{0, 0, 1, 1, 0, 0};
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    aprl_dm_req_t dm_req = '0;
    aprl_cfg_req_t cfg_req;
    logic [15:0] pin_i = 16'h0000;
    logic [15:0] pin_o, pin_oe;
    logic [31:0] cfg_rdata, dm_rdata;
    logic [31:0] rnd = 32'h8686;
    logic [31:0] rw_val[16];
    logic [31:0] dm_q[$];
    logic cfg_ack, dm_ack, lb_act;
    int errors = 0;
    int cmp_count = 0;
    int src;

    always #50 clk_i = ~clk_i;

    aprl_host host (.clk_i(clk_i), .cfg_req_o(cfg_req));
    aprl_regmap DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .cfg_req_i(cfg_req),
        .cfg_rdata_o(cfg_rdata), .cfg_ack_o(cfg_ack), .dm_req_i(dm_req),
        .dm_rdata_o(dm_rdata), .dm_ack_o(dm_ack), .pin_i(pin_i), .pin_o(pin_o),
        .pin_oe_o(pin_oe), .loopback_active_o(lb_act));

    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] x;
        x = v ^ (v << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic rd(input logic [9:0] a, input logic [31:0] e);
        host.access(1'b0, a, 32'h0000_0000, e);
    endtask
    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        host.access(1'b1, a, d, 32'h0000_0000);
    endtask
    task automatic dm(input logic w, input logic [3:0] i, input logic [31:0] d,
                      input logic [31:0] e);
        @(posedge clk_i);
        #1;
        dm_req = '{1'b1, w, i, d};
        dm_q.push_back(e);
        @(posedge clk_i);
        #1;
        dm_req.sel = 1'b0;
    endtask
    task automatic results();
        $display("comparisons %0d, mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // answers are one-cycle pulses, looked at mid-cycle while they stand
    always @(negedge clk_i) begin
        if (cfg_ack === 1'b1) check(cfg_rdata, host.exp_q.pop_front());
        if (dm_ack === 1'b1) check(dm_rdata, dm_q.pop_front());
    end

    initial begin
        #1_000_000;
        errors++;
        results();
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (12) @(posedge clk_i);
        #1;
        rst_n_i = 1'b1;
        rd(OFS_IDENT, IDENT_VALUE);
        for (int i = 0; i < 16; i++) rd(RW_OFS[i], REG_RESET);
        rd(10'h030, 32'h0000_0000);
        wr(10'h030, 32'hFFFF_FFFF);
        rd(10'h030, 32'h0000_0000);
        for (int i = 0; i < 16; i++) begin
            rnd = xs(rnd);
            rw_val[i] = rnd;
            wr(RW_OFS[i], rnd);
        end
        for (int i = 0; i < 16; i++) rd(RW_OFS[i], rw_val[i]);
        $display("test reset values and read-write done");
        rnd = xs(rnd);
        pin_i = rnd[15:0];
        wr(OFS_PIN_DIRECTION, 32'h0000_0000);
        wr(OFS_PIN_FUNCTION_SELECT, 32'h0000_FFFF);
        wr(OFS_POUT, 32'h0000_0F0F);
        wr(OFS_PIN_SET, 32'h0000_00F0);
        rd(OFS_POUT, 32'h0000_0FFF);
        wr(OFS_PCLR, 32'h0000_0303);
        rd(OFS_PCLR, 32'h0000_0CFC);
        rd(OFS_PIN_SET, {16'h0000, rnd[15:0]});
        check({16'h0000, pin_o}, 32'h0000_0CFC);
        $display("test pin set and clear done");
        wr(OFS_GBL, 32'h0000_0000);
        wr(OFS_RX_GBL, 32'hFFFF_FFFF);
        rd(OFS_GBL, GBL_RX_BITS);
        wr(OFS_TX_GBL_FS, 32'hFFFF_FFFF);
        wr(OFS_RX_GBL, 32'h0000_0000);
        rd(OFS_RX_GBL, GBL_TX_BITS);
        rd(OFS_TX_GBL_FS, 32'hFFFF_FFFF);
        $display("test global control aliases done");
        for (int i = 0; i < 6; i++) begin
            wr(OFS_LOOP, 32'(LB_EN[i]) | 32'h0000_0004);
            wr(OFS_TX_GBL_FS, 32'(LB_SLOT[i]) << SLOT_LO);
            host.idle();
            repeat (3) @(posedge clk_i);
            #1;
            check({31'h0, lb_act}, 32'(LB_EXP[i]));
        end
        $display("test loopback gating done");
        // tx slot count 16 keeps only the tx run bit set in the shared ACh word
        for (int o = 0; o < 2; o++) begin
            src = (o == 0) ? 1 : 0;
            rnd = xs(rnd);
            wr(OFS_GBL, 32'h0000_0000);
            wr(OFS_RX_STAT, 32'hFFFF_FFFF);
            host.idle();
            dm(1'b1, 4'(src), rnd, 32'h0000_0000);
            wr(OFS_PIN_FUNCTION_SELECT, 32'h0000_0000);
            wr(OFS_PIN_DIRECTION, 32'h1 << src);
            wr(OFS_RX_BCLK, 32'h0000_001F);
            wr(OFS_RX_FS, 32'h0000_0800);
            // tx clock control lies outside this map; mode 01 keeps both sections in step
            wr(OFS_LOOP, (32'(o) << LOOP_ORDER) | 32'h0000_0005);
            wr(OFS_TX_GBL_FS, 32'h0000_0800);
            wr(OFS_GBL, 32'h0000_0000);
            wr(OFS_GBL, 32'h0000_0808);
            host.idle();
            repeat (300) @(posedge clk_i);
            #1;
            check({31'h0, lb_act}, 32'h0000_0001);
            check({16'h0000, pin_oe}, 32'h1 << src);
            dm(1'b0, 4'(src ^ 1), 32'h0000_0000, rnd);
        end
        $display("test serial loopback done");
        repeat (3) @(posedge clk_i);
        check(32'(host.exp_q.size() + dm_q.size()), 32'h0000_0000);
        results();
    end
endmodule // aprl_regmap_bench

// file: verilog/aprl_lane.sv
`timescale 1ns/1ps
// one serializer: shifts a 32-bit slot out msb first as transmitter,
// or in as receiver, one bit per tick
module aprl_lane (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic xmit_i,
    input wire logic tick_i,
    input wire logic [31:0] load_word_i,
    input wire logic ser_i,
    output logic ser_o,
    output logic [31:0] rx_word_o,
    output logic rx_done_o
);
    import aprl_pkg::*;

    aprl_lane_t l_reg, l_next;

    always_comb begin
        l_next = l_reg;
        l_next.rx_done = 1'b0;
        if (tick_i) begin
            l_next.bit_cnt = l_reg.bit_cnt + 5'h01;
            if (xmit_i) begin
                // next word loaded on the last bit, so its msb stands before the first tick
                if (l_reg.bit_cnt == 5'h1F) begin
                    l_next.shreg = load_word_i;
                end else begin
                    l_next.shreg = {l_reg.shreg[30:0], 1'b0};
                end
            end else begin
                l_next.shreg = {l_reg.shreg[30:0], ser_i};
                if (l_reg.bit_cnt == 5'h1F) begin
                    l_next.rx_word = {l_reg.shreg[30:0], ser_i};
                    l_next.rx_done = 1'b1;
                end
            end
        end else if (xmit_i && l_reg.bit_cnt == 5'h00) begin
            // preload at slot start so a receiver sees bit 31 at its first tick
            l_next.shreg = load_word_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            l_reg <= '0;
        end else begin
            l_reg <= l_next;
        end
    end

    assign ser_o = l_reg.shreg[31];
    assign rx_word_o = l_reg.rx_word;
    assign rx_done_o = l_reg.rx_done;
endmodule // aprl_lane

// file: verilog/aprl_pkg.sv
package aprl_pkg;
    // ----------------------------------------
    // sizes
    // ----------------------------------------
    localparam int NSER = 16;
    localparam int AW = 10;
    localparam int DW = 32;
    // ----------------------------------------
    // register byte offsets and buffer page numbers
    // ----------------------------------------
    localparam logic [9:0] OFS_IDENT = 10'h000;
    localparam logic [9:0] OFS_PWR = 10'h004;
    localparam logic [9:0] OFS_PIN_FUNCTION_SELECT = 10'h010;
    localparam logic [9:0] OFS_PIN_DIRECTION = 10'h014;
    localparam logic [9:0] OFS_POUT = 10'h018;
    localparam logic [9:0] OFS_PIN_SET = 10'h01C;
    localparam logic [9:0] OFS_PCLR = 10'h020;
    localparam logic [9:0] OFS_GBL = 10'h044;
    localparam logic [9:0] OFS_MUTE = 10'h048;
    localparam logic [9:0] OFS_LOOP = 10'h04C;
    localparam logic [9:0] OFS_SPDIF = 10'h050;
    localparam logic [9:0] OFS_RX_GBL = 10'h060;
    localparam logic [9:0] OFS_RX_MASK = 10'h064;
    localparam logic [9:0] OFS_RX_FMT = 10'h068;
    localparam logic [9:0] OFS_RX_FS = 10'h06C;
    localparam logic [9:0] OFS_RX_BCLK = 10'h070;
    localparam logic [9:0] OFS_RX_HCLK = 10'h074;
    localparam logic [9:0] OFS_RX_SLOTS = 10'h078;
    localparam logic [9:0] OFS_RX_INTEN = 10'h07C;
    localparam logic [9:0] OFS_RX_STAT = 10'h080;
    localparam logic [9:0] OFS_RX_CUR = 10'h084;
    localparam logic [9:0] OFS_RX_CHK = 10'h088;
    localparam logic [9:0] OFS_RX_EVT = 10'h08C;
    localparam logic [9:0] OFS_TX_MASK = 10'h0A4;
    localparam logic [9:0] OFS_TX_FMT = 10'h0A8;
    localparam logic [9:0] OFS_TX_GBL_FS = 10'h0AC;
    localparam logic [3:0] PAGE_TX_BUF = 4'h8;
    localparam logic [3:0] PAGE_RX_BUF = 4'hA;
    // ----------------------------------------
    // fields and reset values
    // ----------------------------------------
    localparam logic [31:0] IDENT_VALUE = 32'h00A5_0001; // arbitrary value
    localparam logic [31:0] GBL_RX_BITS = 32'h0000_001F;
    localparam logic [31:0] GBL_TX_BITS = 32'h0000_1F00;
    localparam int GBL_RX_RUN = 3;
    localparam int GBL_TX_RUN = 11;
    localparam int LOOP_EN = 0;
    localparam int LOOP_ORDER = 1;
    localparam int LOOP_MODE_LO = 2;
    localparam logic [1:0] LOOP_MODE_TXCLK = 2'h1;
    localparam int SLOT_LO = 7;
    localparam logic [8:0] SLOT_TDM_MIN = 9'h002;
    localparam logic [8:0] SLOT_TDM_MAX = 9'h020;
    localparam int STAT_RX_READY = 5;
    localparam logic [4:0] TX_BIT_DIV = 5'h03;
    localparam logic [31:0] REG_RESET = 32'h0000_0000;
    // ----------------------------------------
    // carriers
    // ----------------------------------------
    typedef struct packed {
        logic sel;
        logic wr;
        logic [9:0] addr;
        logic [31:0] wdata;
    } aprl_cfg_req_t;

    typedef struct packed {
        logic sel;
        logic wr;
        logic [3:0] idx;
        logic [31:0] wdata;
    } aprl_dm_req_t;

    typedef struct packed {
        logic [31:0] pwr, pin_function_select, pin_direction, pout, gbl, mute, loop, spdif;
        logic [31:0] rx_mask, rx_fmt, rx_fs, rx_bclk, rx_hclk, rx_slots;
        logic [31:0] rx_inten, rx_stat, rx_chk, rx_evt;
        logic [31:0] tx_mask, tx_fmt, tx_fs;
        logic [4:0] rx_cur;
        logic [4:0] tx_cnt, rx_cnt;
        logic [15:0] pin_meta, pin_sync, pin_out, pin_oe;
        logic [15:0][31:0] tx_buf, rx_buf;
        logic cfg_ack, dm_ack, lb_active;
        logic [31:0] cfg_rdata, dm_rdata;
    } aprl_state_t;

    typedef struct packed {
        logic [31:0] shreg;
        logic [4:0] bit_cnt;
        logic [31:0] rx_word;
        logic rx_done;
    } aprl_lane_t;
endpackage

// file: verilog/aprl_regmap.sv
`timescale 1ns/1ps
// Behaviour
// (RL1) loopback routing is active only while the loopback enable bit is 1.
// (RL2) loopback clock field 01b makes the receive section run on the transmit bit clock.
// (RL3) the order select bit picks odd or even serializers as loopback sources.
// (RL4) software sets source serializers to transmit and sink ones to receive first.
// (RL5) software clears the clock independence bit so both sections run together.
// (RL6) software sets both slot counts to 2h..20h for loopback.
// (RL7) loopback is only provided for TDM slot counts, not burst or S/PDIF style; only the tx slot count is checked here, the rx slot count is not.
// (RL8) every control register is read and written by the host at its fixed offset.
// (RL9) transmit and receive buffers are also reached through a second data port.
// (RL10) offset 1Ch reads synced pin levels, and a write sets output bits written 1.
// (RL11) offset 20h clears the output bits written 1 in the same output register.
// (RL12) a write at 60h changes only the receive bits of the global control word.
// (RL13) a write at ACh changes only the transmit bits of the global control word.
// (RL14) in loopback each sink serializer input takes its paired source output.
// (RL15) order 0 feeds odd outputs to even inputs, order 1 even outputs to odd inputs.
// (RL16) a serializer pin with function 0 and direction 1 carries its transmit data.
// (RL17) unlisted offsets read zero and ignore writes.
module aprl_regmap (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input aprl_pkg::aprl_cfg_req_t cfg_req_i,
    output logic [31:0] cfg_rdata_o,
    output logic cfg_ack_o,
    input aprl_pkg::aprl_dm_req_t dm_req_i,
    output logic [31:0] dm_rdata_o,
    output logic dm_ack_o,
    input wire logic [15:0] pin_i,
    output logic [15:0] pin_o,
    output logic [15:0] pin_oe_o,
    output logic loopback_active_o
);
    import aprl_pkg::*;

    aprl_state_t s_reg, s_next;

    // ----------------------------------------
    // loopback and clocking decisions
    // ----------------------------------------
    logic [8:0] tx_slots;
    logic [8:0] rx_slots;
    logic tdm_ok;
    logic lb_now;
    logic share_clk;
    logic tx_tick;
    logic rx_tick_own;
    logic rx_tick;
    logic [15:0] ser_out;
    logic [15:0] ser_in;
    logic [15:0] sink;
    logic [15:0][31:0] lane_word;
    logic [15:0] lane_done;

    assign tx_slots = s_reg.tx_fs[SLOT_LO +: 9];
    assign rx_slots = s_reg.rx_fs[SLOT_LO +: 9];
    // burst (0) and S/PDIF style (180h) fall outside this range
    assign tdm_ok = (tx_slots >= SLOT_TDM_MIN) && (tx_slots <= SLOT_TDM_MAX); // [RL7]
    assign lb_now = s_reg.loop[LOOP_EN] && tdm_ok; // [RL1] [RL7]
    assign share_clk = lb_now
        && (s_reg.loop[LOOP_MODE_LO +: 2] == LOOP_MODE_TXCLK);
    // tx bit divider is fixed; its control register is outside this map
    assign tx_tick = s_reg.gbl[GBL_TX_RUN] && (s_reg.tx_cnt == TX_BIT_DIV);
    assign rx_tick_own = s_reg.gbl[GBL_RX_RUN] && (s_reg.rx_cnt == s_reg.rx_bclk[4:0]);
    assign rx_tick = share_clk ? (tx_tick && s_reg.gbl[GBL_RX_RUN]) : rx_tick_own; // [RL2]

    // ----------------------------------------
    // serializers
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < NSER; g++) begin : g_lane
            // order 0: even lanes sink; order 1: odd lanes sink
            assign sink[g] = s_reg.loop[LOOP_ORDER] ? (g % 2 == 1) : (g % 2 == 0); // [RL3]
            assign ser_in[g] = (lb_now && sink[g]) ? ser_out[g ^ 1] // [RL14] [RL15]
                                                   : s_reg.pin_sync[g];
            aprl_lane u_lane (
                .clk_i(clk_i),
                // section held in reset while its run bit is clear, keeps slots aligned
                .rst_n_i(rst_n_i && (s_reg.pin_direction[g] ? s_reg.gbl[GBL_TX_RUN]
                                                   : s_reg.gbl[GBL_RX_RUN])),
                // direction taken from software setup [RL4]
                .xmit_i(s_reg.pin_direction[g]),
                .tick_i(s_reg.pin_direction[g] ? tx_tick : rx_tick),
                .load_word_i(s_reg.tx_buf[g]),
                .ser_i(ser_in[g]),
                .ser_o(ser_out[g]),
                .rx_word_o(lane_word[g]),
                .rx_done_o(lane_done[g])
            );
        end
    endgenerate

    // ----------------------------------------
    // register read mux
    // ----------------------------------------
    function automatic logic [31:0] read_reg(input aprl_state_t s, input logic [9:0] a);
        logic [31:0] v;
        v = 32'h0000_0000;
        if (a[9:6] == PAGE_TX_BUF) begin
            v = s.tx_buf[a[5:2]];
        end else if (a[9:6] == PAGE_RX_BUF) begin
            v = s.rx_buf[a[5:2]];
        end else begin
            unique case (a)
                OFS_IDENT: v = IDENT_VALUE;
                OFS_PWR: v = s.pwr;
                OFS_PIN_FUNCTION_SELECT: v = s.pin_function_select;
                OFS_PIN_DIRECTION: v = s.pin_direction;
                OFS_POUT: v = s.pout;
                OFS_PIN_SET: v = {16'h0000, s.pin_sync}; // [RL10]
                OFS_PCLR: v = s.pout;
                OFS_GBL: v = s.gbl;
                OFS_MUTE: v = s.mute;
                OFS_LOOP: v = s.loop;
                OFS_SPDIF: v = s.spdif;
                OFS_RX_GBL: v = s.gbl;
                OFS_RX_MASK: v = s.rx_mask;
                OFS_RX_FMT: v = s.rx_fmt;
                OFS_RX_FS: v = s.rx_fs;
                OFS_RX_BCLK: v = s.rx_bclk;
                OFS_RX_HCLK: v = s.rx_hclk;
                OFS_RX_SLOTS: v = s.rx_slots;
                OFS_RX_INTEN: v = s.rx_inten;
                OFS_RX_STAT: v = s.rx_stat;
                OFS_RX_CUR: v = {27'h0000000, s.rx_cur};
                OFS_RX_CHK: v = s.rx_chk;
                OFS_RX_EVT: v = s.rx_evt;
                OFS_TX_MASK: v = s.tx_mask;
                OFS_TX_FMT: v = s.tx_fmt;
                OFS_TX_GBL_FS: v = s.tx_fs;
                default: v = 32'h0000_0000; // [RL17]
            endcase
        end
        return v;
    endfunction

    // ----------------------------------------
    // next state
    // ----------------------------------------
    logic cfg_wr;
    logic [31:0] wd;
    logic any_done;

    assign cfg_wr = cfg_req_i.sel && cfg_req_i.wr;
    assign wd = cfg_req_i.wdata;
    assign any_done = |lane_done;

    always_comb begin
        s_next = s_reg;
        s_next.pin_meta = pin_i;
        s_next.pin_sync = s_reg.pin_meta;
        s_next.lb_active = lb_now;
        s_next.tx_cnt = tx_tick || !s_reg.gbl[GBL_TX_RUN] ? 5'h00 : s_reg.tx_cnt + 5'h01;
        s_next.rx_cnt = rx_tick_own || !s_reg.gbl[GBL_RX_RUN] ? 5'h00
                                                               : s_reg.rx_cnt + 5'h01;
        s_next.cfg_ack = cfg_req_i.sel;
        s_next.cfg_rdata = cfg_req_i.sel && !cfg_req_i.wr
                           ? read_reg(s_reg, cfg_req_i.addr) : 32'h0000_0000; // [RL8]
        s_next.dm_ack = dm_req_i.sel;
        s_next.dm_rdata = dm_req_i.sel && !dm_req_i.wr
                          ? s_reg.rx_buf[dm_req_i.idx] : 32'h0000_0000; // [RL9]
        if (dm_req_i.sel && dm_req_i.wr) begin
            s_next.tx_buf[dm_req_i.idx] = dm_req_i.wdata; // [RL9]
        end
        if (cfg_wr) begin
            if (cfg_req_i.addr[9:6] == PAGE_TX_BUF) begin
                s_next.tx_buf[cfg_req_i.addr[5:2]] = wd;
            end else begin
                unique case (cfg_req_i.addr)
                    OFS_PWR: s_next.pwr = wd;
                    OFS_PIN_FUNCTION_SELECT: s_next.pin_function_select = wd;
                    OFS_PIN_DIRECTION: s_next.pin_direction = wd;
                    OFS_POUT: s_next.pout = wd;
                    OFS_PIN_SET: s_next.pout = s_reg.pout | wd; // [RL10]
                    OFS_PCLR: s_next.pout = s_reg.pout & ~wd; // [RL11]
                    OFS_GBL: s_next.gbl = wd;
                    OFS_MUTE: s_next.mute = wd;
                    OFS_LOOP: s_next.loop = wd;
                    OFS_SPDIF: s_next.spdif = wd;
                    OFS_RX_GBL: s_next.gbl = (s_reg.gbl & ~GBL_RX_BITS)
                                             | (wd & GBL_RX_BITS); // [RL12]
                    OFS_RX_MASK: s_next.rx_mask = wd;
                    OFS_RX_FMT: s_next.rx_fmt = wd;
                    OFS_RX_FS: s_next.rx_fs = wd;
                    OFS_RX_BCLK: s_next.rx_bclk = wd;
                    OFS_RX_HCLK: s_next.rx_hclk = wd;
                    OFS_RX_SLOTS: s_next.rx_slots = wd;
                    OFS_RX_INTEN: s_next.rx_inten = wd;
                    OFS_RX_STAT: s_next.rx_stat = s_reg.rx_stat & ~wd;
                    OFS_RX_CHK: s_next.rx_chk = wd;
                    OFS_RX_EVT: s_next.rx_evt = wd;
                    OFS_TX_MASK: s_next.tx_mask = wd;
                    OFS_TX_FMT: s_next.tx_fmt = wd;
                    // this offset is shared: tx alias bits and tx frame control
                    OFS_TX_GBL_FS: begin
                        s_next.gbl = (s_reg.gbl & ~GBL_TX_BITS)
                                     | (wd & GBL_TX_BITS); // [RL13]
                        s_next.tx_fs = wd;
                    end
                    default: s_next.pwr = s_reg.pwr; // [RL17]
                endcase
            end
        end
        // received words; hardware set beats a same-cycle clear
        for (int i = 0; i < NSER; i++) begin
            if (lane_done[i]) begin
                s_next.rx_buf[i] = lane_word[i]; // [RL14]
            end
        end
        if (any_done) begin
            s_next.rx_stat[STAT_RX_READY] = 1'b1;
            s_next.rx_cur = (({4'h0, s_reg.rx_cur} + 9'h001 >= rx_slots) && rx_slots != 9'h000)
                            ? 5'h00 : s_reg.rx_cur + 5'h01;
        end
        // serializer pins drive tx data, gpio pins drive the output register
        for (int i = 0; i < NSER; i++) begin
            s_next.pin_oe[i] = s_reg.pin_direction[i];
            s_next.pin_out[i] = s_reg.pin_function_select[i] ? s_reg.pout[i] : ser_out[i]; // [RL16]
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign cfg_rdata_o = s_reg.cfg_rdata;
    assign cfg_ack_o = s_reg.cfg_ack;
    assign dm_rdata_o = s_reg.dm_rdata;
    assign dm_ack_o = s_reg.dm_ack;
    assign pin_o = s_reg.pin_out;
    assign pin_oe_o = s_reg.pin_oe;
    assign loopback_active_o = s_reg.lb_active;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    logic cfg_write_seen;
    assign cfg_write_seen = cfg_req_i.sel && cfg_req_i.wr;

    sequence cfg_read_of(logic [9:0] a);
        cfg_req_i.sel && !cfg_req_i.wr && cfg_req_i.addr == a;
    endsequence

    sequence cfg_write_of(logic [9:0] a);
        cfg_write_seen && cfg_req_i.addr == a;
    endsequence

    a_lb_gate: assert property (!s_reg.loop[LOOP_EN] |=> !loopback_active_o) // [RL1]
        else $error("loopback active while disabled");
    a_tdm_only: assert property (!tdm_ok |=> !loopback_active_o) // [RL7]
        else $error("loopback active outside tdm slot range");
    a_clk_shared: assert property (share_clk && s_reg.gbl[GBL_RX_RUN]
                                   |-> rx_tick == tx_tick) // [RL2]
        else $error("receive not on transmit bit clock");
    a_route_pair: assert property (lb_now && sink[2] |-> ser_in[2] == ser_out[3]
                                   && ser_in[3] == s_reg.pin_sync[3] || s_reg.loop[LOOP_ORDER]) // [RL15]
        else $error("order 0 routing wrong");
    a_route_odd: assert property (lb_now && s_reg.loop[LOOP_ORDER]
                                  |-> ser_in[5] == ser_out[4]) // [RL14]
        else $error("order 1 routing wrong");
    a_set_bits: assert property (cfg_write_of(OFS_PIN_SET)
                                 |=> (s_reg.pout & $past(wd)) == $past(wd)) // [RL10]
        else $error("set write lost a bit");
    a_clr_bits: assert property (cfg_write_of(OFS_PCLR)
                                 |=> (s_reg.pout & $past(wd)) == 32'h0000_0000) // [RL11]
        else $error("clear write left a bit");
    a_rx_alias: assert property (cfg_write_of(OFS_RX_GBL)
                                 |=> (s_reg.gbl & ~GBL_RX_BITS)
                                     == ($past(s_reg.gbl) & ~GBL_RX_BITS)) // [RL12]
        else $error("receive alias touched other bits");
    a_tx_alias: assert property (cfg_write_of(OFS_TX_GBL_FS)
                                 |=> (s_reg.gbl & ~GBL_TX_BITS)
                                     == ($past(s_reg.gbl) & ~GBL_TX_BITS)) // [RL13]
        else $error("transmit alias touched other bits");
    a_pin_read: assert property (cfg_read_of(OFS_PIN_SET)
                                 |=> cfg_ack_o && cfg_rdata_o[15:0] == $past(s_reg.pin_sync)) // [RL10]
        else $error("pin read wrong");
    a_unmapped_zero: assert property (cfg_read_of(10'h03C) |=> cfg_ack_o
                                      && cfg_rdata_o == 32'h0000_0000) // [RL17]
        else $error("unmapped offset not zero");
    a_loop_rdback: assert property (cfg_read_of(OFS_LOOP) |=> cfg_rdata_o
                                    == $past(s_reg.loop)) // [RL8]
        else $error("control register readback wrong");
    a_dm_write: assert property (dm_req_i.sel && dm_req_i.wr ##1 dm_req_i.sel
                                 && !dm_req_i.wr && cfg_req_i.sel == 1'b0 |=> dm_ack_o) // [RL9]
        else $error("data port not answering");
    a_pin_drive: assert property (!s_reg.pin_function_select[0] && s_reg.pin_direction[0]
                                  ##1 $stable(s_reg.pin_function_select[0]) |-> pin_oe_o[0]
                                  && pin_o[0] == $past(ser_out[0])) // [RL16]
        else $error("transmit data not on pin");
endmodule // aprl_regmap
